// *** pcs_regs.sv ***
// Purpose: Calibration status, interrupt enable, lot code and test registers.
// Assumes: Events come from engines on mclk; the zero-detect flag comes from a pin.
// Notes:   Read data appear the cycle after the read strobe, and only then.
//
// The implementer's own choice: the strobed register port.
`default_nettype none

module pcs_regs (
	input  wire logic             mclk,       // Clock, 250 MHz.
	input  wire logic             rst_b,      // Async reset, active low.
	input  wire logic             ce,         // Clock enable; freezes all state.
	input  wire pcs_pkg::pcs_req_t req,       // Register request.
	input  wire pcs_pkg::pcs_evt_t evt,       // Engine event pulses.
	input  wire logic             zero_pin,   // Zero-detect level from outside.
	output var  logic [7:0]       rdata,      // Read data.
	output var  logic [7:0]       ofs_dec_en, // Auto decrement enable copy, bit 0.
	output var  logic             irq_b,      // Interrupt, active low.
	output var  logic             irq_oe_b,   // Open-drain enable, low drives.
	output var  logic [7:0]       test_val    // Factory test setting.
);
	import pcs_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] cal_cfg;
		logic [7:0] irq_en;
		logic [7:0] test;
		logic [7:0] rdata;
		logic       cal_irq;
		logic       ofs_dec;
		logic       prox_irq;
		logic       sat_irq;
		logic       zero_irq;
		logic       zero_prev;
		logic       prox_near;
		logic       irq_b;
		logic [7:0] dec_en;
	} pcs_st_t;

	pcs_st_t st_q;
	pcs_st_t st_d;
	logic    zero_lvl;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic s);
		hit = s && (a == b);
	endfunction

	pcs_sync u_zero_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.ce    (ce),
		.din   (zero_pin),
		.dout  (zero_lvl)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic w_stat;
		logic w_main;
		logic prox_ev;
		st_d    = st_q;
		prox_ev = 1'b0;
		w_stat  = hit(req.addr, PCS_ADDR_CAL_STAT, req.wr);
		w_main = hit(req.addr, PCS_ADDR_STATUS, req.wr);

		if (hit(req.addr, PCS_ADDR_IRQ_EN, req.wr)) begin
			st_d.irq_en = req.wdata; // RULE8
		end
		if (hit(req.addr, PCS_ADDR_TEST, req.wr)) begin
			st_d.test = req.wdata;
		end
		if (hit(req.addr, PCS_ADDR_CAL_CFG, req.wr)) begin
			st_d.cal_cfg = req.wdata;
		end

		// Writing one clears a flag; a same-cycle event still wins.
		if (w_stat && req.wdata[PCS_BIT_OFS_DEC]) begin
			st_d.ofs_dec = 1'b0; // RULE2
		end
		if (!st_d.cal_cfg[PCS_BIT_AUTO_DEC]) begin
			st_d.ofs_dec = 1'b0; // RULE3
		end else if (evt.ofs_dec) begin
			st_d.ofs_dec = 1'b1; // RULE1
		end

		if (w_main) begin
			if (req.wdata[PCS_BIT_ST_CAL]) st_d.cal_irq = 1'b0; // RULE5
			if (req.wdata[PCS_BIT_ST_PROX]) st_d.prox_irq = 1'b0;
			if (req.wdata[PCS_BIT_ST_SAT]) st_d.sat_irq = 1'b0;
			if (req.wdata[PCS_BIT_ST_ZERO]) st_d.zero_irq = 1'b0;
		end
		if (evt.cal_done) begin
			st_d.cal_irq = 1'b1; // RULE12
		end

		// Level mode flags every cycle outside the window; state mode only on a change of state.
		if (evt.prox_above) begin
			st_d.prox_near = 1'b1;
		end else if (evt.prox_below) begin
			st_d.prox_near = 1'b0;
		end
		if (st_q.irq_en[PCS_BIT_PROX_MODE]) begin // RULE6
			prox_ev = (evt.prox_above && !st_q.prox_near) || (evt.prox_below && st_q.prox_near);
		end else begin
			prox_ev = evt.prox_above || evt.prox_below;
		end
		if (prox_ev) begin
			st_d.prox_irq = 1'b1; // RULE7
		end
		if (evt.prox_sat) begin
			st_d.sat_irq = 1'b1;
		end
		st_d.zero_prev = zero_lvl;
		if (zero_lvl && !st_q.zero_prev) begin
			st_d.zero_irq = 1'b1;
		end

		st_d.rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				PCS_ADDR_CAL_STAT: begin
					st_d.rdata[PCS_BIT_OFS_DEC]  = st_q.ofs_dec;
					st_d.rdata[PCS_BIT_CAL_DONE] = st_q.cal_irq; // RULE4
				end
				PCS_ADDR_IRQ_EN:   st_d.rdata = st_q.irq_en;
				PCS_ADDR_CAL_CFG:  st_d.rdata = st_q.cal_cfg;
				PCS_ADDR_LOT_LOW:  st_d.rdata = PCS_LOT_LOW_DEF; // RULE9
				PCS_ADDR_LOT_HIGH: st_d.rdata = PCS_LOT_HIGH_DEF; // RULE9
				PCS_ADDR_TEST:     st_d.rdata = st_q.test;
				PCS_ADDR_STATUS: begin
					st_d.rdata[PCS_BIT_ST_PROX] = st_q.prox_irq;
					st_d.rdata[PCS_BIT_ST_SAT]  = st_q.sat_irq;
					st_d.rdata[PCS_BIT_ST_CAL]  = st_q.cal_irq;
					st_d.rdata[PCS_BIT_ST_ZERO] = st_q.zero_irq;
				end
				default:           st_d.rdata = 8'h00;
			endcase
		end

		st_d.irq_b = !((st_d.prox_irq && st_d.irq_en[PCS_BIT_PROX_EN])
			|| (st_d.sat_irq && st_d.irq_en[PCS_BIT_SAT_EN])
			|| (st_d.cal_irq && st_d.irq_en[PCS_BIT_CAL_EN])
			|| (st_d.zero_irq && st_d.irq_en[PCS_BIT_ZERO_EN])); // RULE13
		st_d.dec_en = {7'h00, st_d.cal_cfg[PCS_BIT_AUTO_DEC]};
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q         <= '0;
			st_q.cal_cfg <= PCS_RST_CAL_CFG;
			st_q.irq_b   <= 1'b1;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign rdata      = st_q.rdata;
	assign ofs_dec_en = st_q.dec_en;
	assign irq_b      = st_q.irq_b;
	assign irq_oe_b   = st_q.irq_b;
	assign test_val   = st_q.test;

	// ****************************************
	// Checks
	// ****************************************
	property p_ofs_set;
		@(posedge mclk) disable iff (!rst_b)
		ce && evt.ofs_dec && st_d.cal_cfg[PCS_BIT_AUTO_DEC] |=> st_q.ofs_dec;
	endproperty
	a_ofs_set: assert property (p_ofs_set) else $error("Offset flag not set."); // RULE1

	property p_ofs_w1c;
		@(posedge mclk) disable iff (!rst_b)
		ce && hit(req.addr, PCS_ADDR_CAL_STAT, req.wr) && req.wdata[PCS_BIT_OFS_DEC]
			&& !evt.ofs_dec |=> !st_q.ofs_dec;
	endproperty
	a_ofs_w1c: assert property (p_ofs_w1c) else $error("Offset flag not cleared."); // RULE2

	property p_ofs_en;
		@(posedge mclk) disable iff (!rst_b)
		!st_q.cal_cfg[PCS_BIT_AUTO_DEC] |-> !st_q.ofs_dec;
	endproperty
	a_ofs_en: assert property (p_ofs_en) else $error("Offset flag with decrement off."); // RULE3

	sequence s_stat_rd;
		ce && hit(req.addr, PCS_ADDR_CAL_STAT, req.rd);
	endsequence
	property p_mirror;
		@(posedge mclk) disable iff (!rst_b)
		s_stat_rd ##1 1'b1 |-> rdata[PCS_BIT_CAL_DONE] == $past(st_q.cal_irq);
	endproperty
	a_mirror: assert property (p_mirror) else $error("Done bit not a copy."); // RULE4

	property p_cal_clr;
		@(posedge mclk) disable iff (!rst_b)
		ce && hit(req.addr, PCS_ADDR_STATUS, req.wr) && req.wdata[PCS_BIT_ST_CAL]
			&& !evt.cal_done |=> !st_q.cal_irq;
	endproperty
	a_cal_clr: assert property (p_cal_clr) else $error("Done flag not cleared."); // RULE5

	property p_state_mode;
		@(posedge mclk) disable iff (!rst_b)
		ce && st_q.irq_en[PCS_BIT_PROX_MODE] && st_q.prox_near && evt.prox_above
			&& !evt.prox_below && !st_q.prox_irq && !hit(req.addr, PCS_ADDR_STATUS, req.wr)
			|=> !st_q.prox_irq;
	endproperty
	a_state_mode: assert property (p_state_mode) else $error("State mode repeat."); // RULE6

	property p_level_mode;
		@(posedge mclk) disable iff (!rst_b)
		ce && !st_q.irq_en[PCS_BIT_PROX_MODE] && evt.prox_above |=> st_q.prox_irq;
	endproperty
	a_level_mode: assert property (p_level_mode) else $error("Level mode miss."); // RULE7

	property p_cal_set;
		@(posedge mclk) disable iff (!rst_b)
		ce && evt.cal_done |=> st_q.cal_irq;
	endproperty
	a_cal_set: assert property (p_cal_set) else $error("Calibration flag not set."); // RULE12

	property p_irq;
		@(posedge mclk) disable iff (!rst_b)
		ce && evt.cal_done && st_d.irq_en[PCS_BIT_CAL_EN] |=> !irq_b;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt not driven."); // RULE13

	property p_en_hold;
		@(posedge mclk) disable iff (!rst_b)
		ce && hit(req.addr, PCS_ADDR_IRQ_EN, req.wr) |=> st_q.irq_en == $past(req.wdata);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("Enable write lost."); // RULE8

	property p_lot;
		@(posedge mclk) disable iff (!rst_b)
		ce && hit(req.addr, PCS_ADDR_LOT_LOW, req.rd) |=> rdata == PCS_LOT_LOW_DEF;
	endproperty
	a_lot: assert property (p_lot) else $error("Lot code wrong."); // RULE9

	// ****************************************
	// Flag and pin checks
	// ****************************************
	// First crossing in state mode must flag and move the tracked side.
	sequence s_state_first;
		ce && st_q.irq_en[PCS_BIT_PROX_MODE] && !st_q.prox_near && evt.prox_above;
	endsequence
	property p_state_set;
		@(posedge mclk) disable iff (!rst_b)
		s_state_first |=> st_q.prox_irq && st_q.prox_near;
	endproperty
	a_state_set: assert property (p_state_set) else $error("State mode change missed."); // RULE6

	property p_sat_set;
		@(posedge mclk) disable iff (!rst_b)
		ce && evt.prox_sat |=> st_q.sat_irq && (!st_q.irq_en[PCS_BIT_SAT_EN] || !irq_b);
	endproperty
	a_sat_set: assert property (p_sat_set) else $error("Saturation flag not set."); // RULE13

	property p_zero_set;
		@(posedge mclk) disable iff (!rst_b)
		ce && zero_lvl && !st_q.zero_prev
			|=> st_q.zero_irq && (!st_q.irq_en[PCS_BIT_ZERO_EN] || !irq_b);
	endproperty
	a_zero_set: assert property (p_zero_set) else $error("Zero flag not set."); // RULE13

	// Clearing every flag with no event in flight must let the line go.
	property p_irq_release;
		@(posedge mclk) disable iff (!rst_b)
		ce && hit(req.addr, PCS_ADDR_STATUS, req.wr) && req.wdata[PCS_BIT_ST_PROX]
			&& req.wdata[PCS_BIT_ST_SAT] && req.wdata[PCS_BIT_ST_CAL]
			&& req.wdata[PCS_BIT_ST_ZERO] && (evt == '0) && !(zero_lvl && !st_q.zero_prev)
			|=> irq_b && irq_oe_b;
	endproperty
	a_irq_release: assert property (p_irq_release) else $error("Interrupt not released."); // RULE13

	property p_freeze;
		@(posedge mclk) disable iff (!rst_b)
		!ce |=> st_q == $past(st_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("State moved while disabled.");

	property p_rd_idle;
		@(posedge mclk) disable iff (!rst_b)
		ce && !req.rd |=> rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("Read data outside read slot.");
endmodule // pcs_regs

`default_nettype wire

// *** pcs_pkg.sv ***
// Purpose: Constants and carrier types for the proximity calibration status register slice.
// Assumes: Byte-wide registers on a plain strobe port, one clock, active-low async reset.
// Notes:   Offsets are byte addresses on the plain register port.
//
// Behaviour
// RULE1 - Set offset-decremented flag when auto decrement is enabled and lowers the offset.
// RULE2 - Writing one to the offset-decremented flag clears it; zero leaves it.
// RULE3 - Clearing the auto decrement enable also clears the offset-decremented flag.
// RULE4 - Calibration status bit 0 mirrors the calibration interrupt flag.
// RULE5 - Calibration-done bit clears together with the calibration interrupt flag.
// RULE6 - Interrupt enable bit 5 selects level (0) or state (1) proximity interrupts.
// RULE7 - The mode decides when the proximity flag sets and raises its interrupt.
// RULE8 - Enables: proximity bit 4, saturation bit 3, calibration bit 2, zero bit 1.
// RULE9 - Two read-only lot code registers hold part-specific factory data.
// RULE10 - Host programs the factory test register to seven; it resets to zero.
// RULE11 - Host writes reserved bits with their reset default values.
// RULE12 - Calibration interrupt flag sets when offset calibration completes.
// RULE13 - Active-low interrupt drives while any enabled flag is set.
`default_nettype none

package pcs_pkg;

	localparam logic [7:0] PCS_ADDR_CAL_STAT  = 8'hdc;
	localparam logic [7:0] PCS_ADDR_IRQ_EN    = 8'hdd;
	localparam logic [7:0] PCS_ADDR_LOT_LOW   = 8'he5;
	localparam logic [7:0] PCS_ADDR_LOT_HIGH  = 8'he6;
	localparam logic [7:0] PCS_ADDR_TEST      = 8'hf9;
	localparam logic [7:0] PCS_ADDR_STATUS    = 8'hdf;
	localparam logic [7:0] PCS_ADDR_CAL_CFG   = 8'hd9;

	localparam int PCS_BIT_CAL_DONE   = 0;
	localparam int PCS_BIT_OFS_DEC    = 2;
	localparam int PCS_BIT_ZERO_EN    = 1;
	localparam int PCS_BIT_CAL_EN     = 2;
	localparam int PCS_BIT_SAT_EN     = 3;
	localparam int PCS_BIT_PROX_EN    = 4;
	localparam int PCS_BIT_PROX_MODE  = 5;
	localparam int PCS_BIT_AUTO_DEC   = 3;
	localparam int PCS_BIT_ST_ZERO    = 0;
	localparam int PCS_BIT_ST_CAL     = 3;
	localparam int PCS_BIT_ST_SAT     = 4;
	localparam int PCS_BIT_ST_PROX    = 5;

	localparam logic [7:0] PCS_RST_CAL_CFG = 8'h50;
	localparam logic [7:0] PCS_RST_ZERO    = 8'h00;
	localparam logic [7:0] PCS_LOT_LOW_DEF  = 8'h5a;
	localparam logic [7:0] PCS_LOT_HIGH_DEF = 8'ha5;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pcs_req_t;

	typedef struct packed {
		logic cal_done;
		logic ofs_dec;
		logic prox_above;
		logic prox_below;
		logic prox_sat;
		logic zero_det;
	} pcs_evt_t;

endpackage : pcs_pkg

`default_nettype wire

// *** pcs_sync.sv ***
// Purpose: Four-flop input qualifier for a pin from outside the clock domain.
// Assumes: Input may change at any time relative to mclk.
// Notes:   Output only moves once the second and third stages agree.
`default_nettype none

module pcs_sync (
	input  wire logic mclk,   // Clock.
	input  wire logic rst_b,  // Async reset, active low.
	input  wire logic ce,     // Clock enable.
	input  wire logic din,    // Raw asynchronous input.
	output var  logic dout    // Qualified level.
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} pcs_sync_st_t;

	pcs_sync_st_t st_q;
	pcs_sync_st_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.q = st_q.s3;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.q;
endmodule // pcs_sync

`default_nettype wire

// *** pcs_host.sv ***
// Purpose: Host model driving the plain register port of the slice.
// Assumes: Strobes last one cycle and change by NBA just after a rising edge.
// Notes:   Released address and data show inverted values, never the last ones.
`default_nettype none

module pcs_host (
	input  wire logic              mclk,  // Clock.
	input  wire logic [7:0]        rdata, // Read data from the slice.
	output var  pcs_pkg::pcs_req_t req    // Register request.
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;

	initial req = '0;

	// Callers keep reserved bits at their defaults.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		req <= '{~a, ~d, 1'b0, 1'b0};
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		req <= '{~a, 8'hff, 1'b0, 1'b0};
		#1 d = rdata;
	endtask
endmodule // pcs_host

`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the calibration status register slice.
// Assumes: A reference model kept in integers mirrors every register and flag.
// Notes:   Irq is checked with every read, two edges after the last change.
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;

	logic              mclk = 0, rst_b = 0, ce = 1, zero_pin = 0;
	pcs_evt_t          evt = '0;
	pcs_req_t          req;
	logic [7:0]        rdata, ofs_dec_en, test_val;
	logic              irq_b, irq_oe_b;
	int                error_cnt = 0, checks = 0;
	int                m_en, m_st, m_cfg = 'h50, m_ofs, m_test, m_near;
	logic [7:0]        addrs [6] = '{8'hdc, 8'hdd, 8'he5, 8'he6, 8'hf9, 8'h00};

	always #2 mclk = ~mclk;

	pcs_host i_host (.mclk(mclk), .rdata(rdata), .req(req));
	pcs_regs i_pcs_regs (.mclk(mclk), .rst_b(rst_b), .ce(ce), .req(req), .evt(evt),
		.zero_pin(zero_pin), .rdata(rdata), .ofs_dec_en(ofs_dec_en), .irq_b(irq_b),
		.irq_oe_b(irq_oe_b), .test_val(test_val));

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			PCS_ADDR_CAL_STAT: return 8'((m_ofs << 2) | ((m_st >> 3) & 1));
			PCS_ADDR_IRQ_EN:   return 8'(m_en);
			PCS_ADDR_LOT_LOW:  return PCS_LOT_LOW_DEF;
			PCS_ADDR_LOT_HIGH: return PCS_LOT_HIGH_DEF;
			PCS_ADDR_TEST:     return 8'(m_test);
			PCS_ADDR_STATUS:   return 8'(m_st);
			PCS_ADDR_CAL_CFG:  return 8'(m_cfg);
			default:           return 8'h00;
		endcase
	endfunction

	function automatic logic exp_irq();
		return !(m_en[4] & m_st[5] | m_en[3] & m_st[4] | m_en[2] & m_st[3] | m_en[1] & m_st[0]);
	endfunction

	task automatic cr(input logic [7:0] a);
		logic [7:0] d;
		i_host.rd(a, d);
		`CHK(d, exp_rd(a))
		`CHK(irq_b, exp_irq())
		`CHK(irq_oe_b, exp_irq())
	endtask

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		i_host.wr(a, d);
		if (a == PCS_ADDR_CAL_STAT && d[2]) m_ofs = 0;
		if (a == PCS_ADDR_IRQ_EN) m_en = d;
		if (a == PCS_ADDR_TEST) m_test = d;
		if (a == PCS_ADDR_STATUS) m_st &= ~d;
		if (a == PCS_ADDR_CAL_CFG) m_cfg = d;
		if (a == PCS_ADDR_CAL_CFG && !d[3]) m_ofs = 0;
	endtask

	task automatic ev(input pcs_evt_t e);
		@(posedge mclk);
		evt <= e;
		@(posedge mclk);
		evt <= '0;
		#1;
		if (e.cal_done) m_st |= 'h08;
		if (e.prox_sat) m_st |= 'h10;
		if (e.ofs_dec && m_cfg[3]) m_ofs = 1;
		if ((e.prox_above || e.prox_below) && (!m_en[5] || e.prox_above != m_near)) m_st |= 'h20;
		if (e.prox_above || e.prox_below) m_near = e.prox_above;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hang guard, far beyond the fewer than two hundred cycles the tests need.
	initial begin
		repeat (3000) @(posedge mclk);
		error_cnt++;
		wrap_up();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(44846));
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (addrs[i]) cr(addrs[i]);
		`CHK(test_val, 8'h00)
		$display("test reset done");
		w(PCS_ADDR_TEST, 8'h07);
		`CHK(test_val, 8'h07)
		w(PCS_ADDR_LOT_LOW, 8'hff);
		cr(PCS_ADDR_LOT_LOW);
		repeat (4) begin
			w(PCS_ADDR_IRQ_EN, 8'($urandom) & 8'h3e);
			cr(PCS_ADDR_IRQ_EN);
		end
		$display("test access done");
		w(PCS_ADDR_IRQ_EN, 8'h04);
		ev(6'b100000);
		cr(PCS_ADDR_CAL_STAT);
		w(PCS_ADDR_STATUS, 8'h08);
		cr(PCS_ADDR_CAL_STAT);
		@(posedge mclk);
		ce  <= 1'b0;
		evt <= 6'b100000;
		@(posedge mclk);
		ce  <= 1'b1;
		evt <= '0;
		cr(PCS_ADDR_CAL_STAT);
		$display("test calibration done");
		w(PCS_ADDR_CAL_CFG, 8'h58);
		ev(6'b010000);
		cr(PCS_ADDR_CAL_STAT);
		`CHK(ofs_dec_en, 8'h01)
		w(PCS_ADDR_CAL_STAT, 8'h00);
		cr(PCS_ADDR_CAL_STAT);
		w(PCS_ADDR_CAL_STAT, 8'h04);
		cr(PCS_ADDR_CAL_STAT);
		ev(6'b010000);
		w(PCS_ADDR_CAL_CFG, 8'h50);
		`CHK(ofs_dec_en, 8'h00)
		cr(PCS_ADDR_CAL_STAT);
		ev(6'b010000);
		cr(PCS_ADDR_CAL_STAT);
		$display("test offset done");
		for (int md = 0; md < 2; md++) begin
			w(PCS_ADDR_IRQ_EN, 8'(md << 5) | 8'h1a);
			repeat (2) begin
				ev(6'b001000);
				cr(PCS_ADDR_STATUS);
				w(PCS_ADDR_STATUS, 8'h20);
			end
			ev(6'b000100);
			cr(PCS_ADDR_STATUS);
			w(PCS_ADDR_STATUS, 8'h20);
		end
		$display("test proximity done");
		ev(6'b000010);
		cr(PCS_ADDR_STATUS);
		@(posedge mclk);
		zero_pin <= 1'b1;
		repeat (6) @(posedge mclk);
		m_st |= 'h01;
		cr(PCS_ADDR_STATUS);
		w(PCS_ADDR_STATUS, 8'h39);
		cr(PCS_ADDR_STATUS);
		$display("test irq done");
		wrap_up();
	end
endmodule // testbench

`default_nettype wire
